// [logic/uabw_cfg.svh]
`ifndef UABW_CFG_SVH
`define UABW_CFG_SVH

// Register word offsets on the APB bus
`define UABW_OFF_CTRL 12'h000
`define UABW_OFF_STAT 12'h004
`define UABW_OFF_DIVL 12'h008
`define UABW_OFF_DIVH 12'h00C
`define UABW_OFF_RBUF 12'h010

// Control register bit positions
`define UABW_CTL_ABEN 0
`define UABW_CTL_WAKE 1
`define UABW_CTL_OVF 2
`define UABW_CTL_WIDE 3
`define UABW_CTL_HSPD 4
`define UABW_CTL_ASYNC 5

// Status register bit positions
`define UABW_STA_RFLAG 0
`define UABW_STA_IDLE 1

// Reset values
`define UABW_RST_DIV 16'h0000
`define UABW_RST_ASYNC 1'b1

// Measurement clock terminal counts: pclk/512, pclk/128, pclk/32
`define UABW_TC_SLOW 9'h1FF
`define UABW_TC_MID 9'h07F
`define UABW_TC_FAST 9'h01F

// Counter start value and rising-edge count seen before the stop bit edge
`define UABW_DIV_START 16'h0001
`define UABW_DIV_MAX 16'hFFFF
`define UABW_EDGE_FIRST 3'h1
`define UABW_EDGE_LAST 3'h4
`define UABW_RBUF_DATA 8'h00

`endif

// [logic/uabw_pkg.sv]
`default_nettype none
package uabw_pkg;

  // Measurement sequence
  typedef enum logic [1:0] {
    UABW_AB_IDLE  = 2'b00,
    UABW_AB_START = 2'b01,
    UABW_AB_EDGE1 = 2'b10,
    UABW_AB_COUNT = 2'b11
  } uabw_ab_state_type;

  // One decoded APB access
  typedef struct packed {
    logic [11:0] addr;
    logic write;
    logic [31:0] wdata;
    logic access;
  } uabw_apb_req_type;

endpackage
`default_nettype wire

// [logic/uabw_core.sv]
// Function
// - Receive line times the measurement counter
// - Enable starts measurement; receiver held idle
// - Counting starts at first rise after start
// - Fifth rise: keep count, clear enable, flag
// - Buffer read clears flag; value discarded
// - Divisor pair forms one 16-bit counter
// - Counter runs at pclk/512, pclk/128 or pclk/32 per select bits
// - Counter starts from one
// - With wake armed, measure following character
// - Overflow flag set before fifth rise wraps
// - After overflow keep counting; normal completion
// - Overflow clear ignored while enable set
// - Wake works only in asynchronous mode
// - Wake armed: reception disabled, watch falling edge
// - Wake event raises receive flag
// - Buffer read clears wake flag
// - Rise after break clears wake enable
// - Non-zero character low time counts as wake
`default_nettype none
`include "uabw_cfg.svh"

module uabw_core #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial line and receiver control
  input wire logic receive_line,
  output logic rx_hold_idle,
  output logic receive_flag
);

  if (ADDR_W != 12) begin : g_bad_addr
    $error("uabw_core: ADDR_W must be 12");
  end

  // Measurement clock terminal count from the two select bits
  function automatic logic [8:0] tc_of(input logic wide, input logic hspd);
    case ({wide, hspd})
      2'b00: tc_of = `UABW_TC_SLOW;
      2'b11: tc_of = `UABW_TC_FAST;
      default: tc_of = `UABW_TC_MID;
    endcase
  endfunction

  uabw_pkg::uabw_apb_req_type req;
  uabw_pkg::uabw_ab_state_type ab_st_ff;
  logic rx_meta_ff, rx_sync_ff, rx_last_ff;
  logic rx_rise, rx_fall;
  logic ab_en_ff, wake_ff, ovf_ff, wide_ff, hspd_ff, async_ff;
  logic wk_low_ff, rflag_ff;
  logic [15:0] div_ff;
  logic [8:0] presc_ff;
  logic [2:0] edges_ff;
  logic [31:0] prdata_ff;
  logic tick, done, wake_evt, wake_end, rd_buf, wr_ctrl, wr_divl, wr_divh, hit;

  // Bus request bundle; accesses complete in one access cycle
  always_comb begin
    req.addr = paddr;
    req.write = pwrite;
    req.wdata = pwdata;
    req.access = psel & penable;
  end

  assign pready = 1'b1;
  assign hit = (req.addr == `UABW_OFF_CTRL) | (req.addr == `UABW_OFF_STAT) |
               (req.addr == `UABW_OFF_DIVL) | (req.addr == `UABW_OFF_DIVH) |
               (req.addr == `UABW_OFF_RBUF);
  assign pslverr = req.access & ~hit;
  assign prdata = prdata_ff;
  assign wr_ctrl = req.access & req.write & (req.addr == `UABW_OFF_CTRL);
  assign wr_divl = req.access & req.write & (req.addr == `UABW_OFF_DIVL);
  assign wr_divh = req.access & req.write & (req.addr == `UABW_OFF_DIVH);
  assign rd_buf = req.access & ~req.write & (req.addr == `UABW_OFF_RBUF);

  // Two-stage synchroniser, then edge detection on the second stage only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_meta_ff <= 1'b1;
      rx_sync_ff <= 1'b1;
      rx_last_ff <= 1'b1;
    end else begin
      rx_meta_ff <= receive_line;
      rx_sync_ff <= rx_meta_ff;
      rx_last_ff <= rx_sync_ff;
    end
  end

  assign rx_rise = rx_sync_ff & ~rx_last_ff;
  assign rx_fall = ~rx_sync_ff & rx_last_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_ff <= 9'h000;
    end else if (ab_st_ff != uabw_pkg::UABW_AB_COUNT || tick) begin
      presc_ff <= 9'h000;
    end else begin
      presc_ff <= presc_ff + 9'h001;
    end
  end

  assign tick = (ab_st_ff == uabw_pkg::UABW_AB_COUNT) && (presc_ff == tc_of(wide_ff, hspd_ff));
  assign done = (ab_st_ff == uabw_pkg::UABW_AB_COUNT) && rx_rise &&
                (edges_ff == `UABW_EDGE_LAST);
  assign wake_evt = wake_ff & ~wk_low_ff & rx_fall & async_ff;
  assign wake_end = wake_ff & wk_low_ff & rx_rise;

  // line times counter
  // Measurement sequencer; the line edges time the counter, not the reverse.
  // A clearing control write drops to idle on the same edge as the enable,
  // so the receiver is never released while the sequencer is still busy.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_st_ff <= uabw_pkg::UABW_AB_IDLE;
    end else if (!ab_en_ff || (wr_ctrl && !req.wdata[`UABW_CTL_ABEN])) begin
      ab_st_ff <= uabw_pkg::UABW_AB_IDLE;
    end else begin
      case (ab_st_ff)
        uabw_pkg::UABW_AB_IDLE: begin
          if (!wake_ff) begin
            ab_st_ff <= uabw_pkg::UABW_AB_START;
          end
        end
        uabw_pkg::UABW_AB_START: begin
          if (rx_fall) begin
            ab_st_ff <= uabw_pkg::UABW_AB_EDGE1;
          end
        end
        uabw_pkg::UABW_AB_EDGE1: begin
          if (rx_rise) begin
            ab_st_ff <= uabw_pkg::UABW_AB_COUNT;
          end
        end
        uabw_pkg::UABW_AB_COUNT: begin
          if (done) begin
            ab_st_ff <= uabw_pkg::UABW_AB_IDLE;
          end
        end
        default: ab_st_ff <= uabw_pkg::UABW_AB_IDLE;
      endcase
    end
  end

  // Rising edges seen since the start bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edges_ff <= 3'h0;
    end else if (ab_st_ff == uabw_pkg::UABW_AB_EDGE1 && rx_rise) begin
      edges_ff <= `UABW_EDGE_FIRST;
    end else if (ab_st_ff == uabw_pkg::UABW_AB_COUNT && rx_rise) begin
      edges_ff <= edges_ff + 3'h1;
    end
  end

  // one counter
  // Both divisor bytes count together; software writes are ignored mid-measure
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_ff <= `UABW_RST_DIV;
    end else if (ab_st_ff == uabw_pkg::UABW_AB_EDGE1 && rx_rise) begin
      div_ff <= `UABW_DIV_START;
    end else if (ab_st_ff == uabw_pkg::UABW_AB_COUNT) begin
      if (tick && !done) begin
        div_ff <= div_ff + 16'h0001;
      end
    end else if (wr_divl) begin
      div_ff[7:0] <= req.wdata[7:0];
    end else if (wr_divh) begin
      div_ff[15:8] <= req.wdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ab_en_ff <= 1'b0;
    end else if (done) begin
      ab_en_ff <= 1'b0;
    end else if (wr_ctrl) begin
      ab_en_ff <= req.wdata[`UABW_CTL_ABEN];
    end
  end

  // guarded clear; set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ovf_ff <= 1'b0;
    end else if (tick && !done && div_ff == `UABW_DIV_MAX) begin
      ovf_ff <= 1'b1;
    end else if (wr_ctrl && !ab_en_ff) begin
      ovf_ff <= req.wdata[`UABW_CTL_OVF];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wake_ff <= 1'b0;
    end else if (wake_end) begin
      wake_ff <= 1'b0;
    end else if (wr_ctrl) begin
      wake_ff <= req.wdata[`UABW_CTL_WAKE] & req.wdata[`UABW_CTL_ASYNC];
    end
  end

  // any low counts
  // Low phase of the wake event; any falling edge is taken, data or break
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wk_low_ff <= 1'b0;
    end else if (!wake_ff || wake_end) begin
      wk_low_ff <= 1'b0;
    end else if (wake_evt) begin
      wk_low_ff <= 1'b1;
    end
  end

  // Plain configuration bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wide_ff <= 1'b0;
      hspd_ff <= 1'b0;
      async_ff <= `UABW_RST_ASYNC;
    end else if (wr_ctrl) begin
      wide_ff <= req.wdata[`UABW_CTL_WIDE];
      hspd_ff <= req.wdata[`UABW_CTL_HSPD];
      async_ff <= req.wdata[`UABW_CTL_ASYNC];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rflag_ff <= 1'b0;
    end else if (done || wake_evt) begin
      rflag_ff <= 1'b1;
    end else if (rd_buf) begin
      rflag_ff <= 1'b0;
    end
  end

  assign rx_hold_idle = ab_en_ff | wake_ff;
  assign receive_flag = rflag_ff;

  // Read data is captured in the setup cycle so it stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_ff <= 32'h0000_0000;
      case (paddr)
        `UABW_OFF_CTRL: begin
          prdata_ff[`UABW_CTL_ABEN] <= ab_en_ff;
          prdata_ff[`UABW_CTL_WAKE] <= wake_ff;
          prdata_ff[`UABW_CTL_OVF] <= ovf_ff;
          prdata_ff[`UABW_CTL_WIDE] <= wide_ff;
          prdata_ff[`UABW_CTL_HSPD] <= hspd_ff;
          prdata_ff[`UABW_CTL_ASYNC] <= async_ff;
        end
        `UABW_OFF_STAT: begin
          prdata_ff[`UABW_STA_RFLAG] <= rflag_ff;
          prdata_ff[`UABW_STA_IDLE] <= (ab_st_ff != uabw_pkg::UABW_AB_COUNT) &&
                                       (ab_st_ff != uabw_pkg::UABW_AB_EDGE1) && !wk_low_ff;
        end
        `UABW_OFF_DIVL: prdata_ff[7:0] <= div_ff[7:0];
        `UABW_OFF_DIVH: prdata_ff[7:0] <= div_ff[15:8];
        `UABW_OFF_RBUF: prdata_ff[7:0] <= `UABW_RBUF_DATA;
        default: prdata_ff <= 32'h0000_0000;
      endcase
    end
  end

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_done_clears;
    done |=> !ab_en_ff && rflag_ff && ab_st_ff == uabw_pkg::UABW_AB_IDLE;
  endproperty
  a_done_clears: assert property (p_done_clears) else $error("completion not signalled");

  property p_start_one;
    (ab_st_ff == uabw_pkg::UABW_AB_EDGE1 && rx_rise && ab_en_ff) |=> div_ff == 16'h0001;
  endproperty
  a_start_one: assert property (p_start_one) else $error("counter not started at one");

  property p_count_step;
    (ab_st_ff == uabw_pkg::UABW_AB_COUNT && tick && !done && ab_en_ff) |=>
      div_ff == 16'($past(div_ff) + 16'h0001);
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step");

  property p_ovf_wrap;
    (tick && !done && div_ff == 16'hFFFF) |=> ovf_ff && div_ff == 16'h0000;
  endproperty
  a_ovf_wrap: assert property (p_ovf_wrap) else $error("overflow missed on wrap");

  property p_ovf_hold;
    (ovf_ff && ab_en_ff && wr_ctrl) |=> ovf_ff;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow cleared while enabled");

  property p_hold_idle;
    (ab_st_ff != uabw_pkg::UABW_AB_IDLE) |-> rx_hold_idle;
  endproperty
  a_hold_idle: assert property (p_hold_idle) else $error("receiver not held idle");

  property p_wait_break;
    (ab_st_ff == uabw_pkg::UABW_AB_IDLE && wake_ff) |=> ab_st_ff == uabw_pkg::UABW_AB_IDLE;
  endproperty
  a_wait_break: assert property (p_wait_break) else $error("measured during break");

  property p_wake_flag;
    (wake_ff && !wk_low_ff && rx_fall && async_ff) |=> rflag_ff && wk_low_ff;
  endproperty
  a_wake_flag: assert property (p_wake_flag) else $error("wake event lost");

  property p_wake_end;
    (wake_ff && wk_low_ff && rx_rise) |=> !wake_ff ##1 !wk_low_ff;
  endproperty
  a_wake_end: assert property (p_wake_end) else $error("wake enable not cleared");

  property p_read_clear;
    (rd_buf && !done && !wake_evt) |=> !rflag_ff;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read did not clear flag");

  property p_first_rise;
    (ab_st_ff == uabw_pkg::UABW_AB_EDGE1 && rx_rise && ab_en_ff && !wr_ctrl) |=>
      ab_st_ff == uabw_pkg::UABW_AB_COUNT && edges_ff == `UABW_EDGE_FIRST;
  endproperty
  a_first_rise: assert property (p_first_rise) else $error("late count start");

  property p_abort_idle;
    (wr_ctrl && !req.wdata[`UABW_CTL_ABEN]) |=>
      !ab_en_ff && ab_st_ff == uabw_pkg::UABW_AB_IDLE;
  endproperty
  a_abort_idle: assert property (p_abort_idle) else $error("abort left sequencer busy");

  property p_sync_no_wake;
    (wr_ctrl && !req.wdata[`UABW_CTL_ASYNC]) |=> !wake_ff;
  endproperty
  a_sync_no_wake: assert property (p_sync_no_wake) else $error("wake armed in sync mode");

  c_done: cover property (done);
  c_ovf_done: cover property (ovf_ff && done);
  c_wake: cover property (wake_evt ##[1:1000] wake_end);
  c_abort: cover property (ab_st_ff == uabw_pkg::UABW_AB_COUNT ##1 !ab_en_ff && !done);

endmodule // uabw_core
`default_nettype wire

// [dv/uabw_line_model.sv]
`default_nettype none
// Remote sender: drives the serial line, idle high, frames sent LSB first
module uabw_line_model (
  // Clock
  input wire logic pclk,
  // Serial line
  output logic receive_line
);
  timeunit 1ns;
  timeprecision 1ps;

  // The line idles high between frames, as a pulled-up line would
  initial receive_line = 1'b1;

  // Hold one level for n clock cycles
  task automatic hold_line(input logic v, input int n);
    receive_line <= v;
    repeat (n) @(posedge pclk);
  endtask

  task automatic send_byte(input logic [7:0] d, input int t);
    @(posedge pclk);
    hold_line(1'b0, t);
    for (int i = 0; i < 8; i++) hold_line(d[i], t);
    hold_line(1'b1, t);
  endtask

  task automatic send_break(input int nbits, input int t);
    @(posedge pclk);
    hold_line(1'b0, nbits * t);
    hold_line(1'b1, t);
  endtask
endmodule // uabw_line_model
`default_nettype wire

// [dv/uart_autobaud_and_wake_on_break_test.sv]
`default_nettype none
`include "uabw_cfg.svh"
module uart_autobaud_and_wake_on_break_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int T = 260; // Bit time in pclk cycles; 8T falls on a tick only at the fast rate
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic receive_line;
  logic rx_hold_idle;
  logic receive_flag;
  logic [31:0] rdata_q;
  logic err_q;
  int fails = 0;
  int n_tests = 0;

  // 50 MHz clock
  always #10 pclk = ~pclk;

  uabw_core #(.ADDR_W(12)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .receive_line(receive_line),
    .rx_hold_idle(rx_hold_idle), .receive_flag(receive_flag));
  uabw_line_model remote (.pclk(pclk), .receive_line(receive_line));

  // Closing report, reached from the main sequence or a timeout
  task automatic test_done;
    $display("Compares %0d, mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // Compare, count and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t %s: got %h want %h", $time, what, got, exp);
    end
  endtask

  // One APB transfer, request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rdata_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      chk(32'h1, 32'h0, "pready timeout");
      test_done();
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0000_0000);
    chk(rdata_q, exp, what);
  endtask

  // Bounded wait for the receive flag
  task automatic wait_flag(input int bound);
    int k;
    k = 0;
    while (receive_flag !== 1'b1 && k < bound) begin
      @(posedge pclk);
      k++;
    end
    if (k >= bound) begin
      chk(32'h1, 32'h0, "flag timeout");
      test_done();
    end
  endtask

  // Divisor must match 8T/n counted from one; prescale phase allows one extra tick
  task automatic chk_div(input int n);
    int exp;
    exp = 1 + (8 * T - 1) / n;
    rd_chk(`UABW_OFF_DIVH, 32'h0000_0000, "high half zero");
    apb(1'b0, `UABW_OFF_DIVL, 32'h0000_0000);
    chk({31'h0, (rdata_q >= exp && rdata_q <= exp + 1)}, 32'h1, "divisor");
    rd_chk(`UABW_OFF_RBUF, 32'h0000_0000, "buffer reads zero");
    rd_chk(`UABW_OFF_STAT, 32'h0000_0002, "flag cleared by read");
  endtask

  task automatic t_reset;
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0020, "ctrl reset");
    rd_chk(`UABW_OFF_STAT, 32'h0000_0002, "status reset");
    rd_chk(`UABW_OFF_DIVL, 32'h0000_0000, "divl reset");
    apb(1'b0, 12'h014, 32'h0000_0000);
    chk({err_q, rdata_q[30:0]}, 32'h8000_0000, "unmapped read");
    $display("t_reset done");
  endtask

  task automatic t_measure(input logic [1:0] sel, input int n);
    wr(`UABW_OFF_CTRL, 32'h0000_0021 | {sel, 3'b000});
    fork
      remote.send_byte(8'h55, T);
      begin
        repeat (5 * T) @(posedge pclk);
        chk({30'h0, rx_hold_idle, receive_flag}, 32'h2, "held idle");
      end
    join
    wait_flag(50);
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0020 | {sel, 3'b000}, "enable self-clear");
    chk_div(n);
    $display("t_measure %b done", sel);
  endtask

  task automatic t_abort;
    wr(`UABW_OFF_CTRL, 32'h0000_0024);
    wr(`UABW_OFF_CTRL, 32'h0000_0025);
    wr(`UABW_OFF_CTRL, 32'h0000_0021);
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0025, "clear held off");
    wr(`UABW_OFF_CTRL, 32'h0000_0024);
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0024, "enable cleared");
    chk({31'h0, rx_hold_idle}, 32'h0, "receiver released");
    wr(`UABW_OFF_CTRL, 32'h0000_0020);
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0020, "abort complete");
    $display("t_abort done");
  endtask

  task automatic t_wake;
    wr(`UABW_OFF_CTRL, 32'h0000_0002);
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0000, "no wake in sync mode");
    rd_chk(`UABW_OFF_STAT, 32'h0000_0002, "idle before arming");
    wr(`UABW_OFF_CTRL, 32'h0000_0022);
    fork
      remote.send_break(13, T);
      begin
        repeat (T) @(posedge pclk);
        chk({30'h0, rx_hold_idle, receive_flag}, 32'h3, "wake flag");
        rd_chk(`UABW_OFF_STAT, 32'h0000_0001, "busy while low");
      end
    join
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0020, "wake self-clear");
    chk({30'h0, rx_hold_idle, receive_flag}, 32'h1, "back to idle");
    rd_chk(`UABW_OFF_RBUF, 32'h0000_0000, "buffer");
    rd_chk(`UABW_OFF_STAT, 32'h0000_0002, "wake flag cleared");
    $display("t_wake done");
  endtask

  task automatic t_wake_frag;
    wr(`UABW_OFF_CTRL, 32'h0000_0022);
    remote.send_byte(8'h55, T);
    chk({31'h0, receive_flag}, 32'h1, "fragment wakes");
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0020, "wake cleared at first rise");
    rd_chk(`UABW_OFF_RBUF, 32'h0000_0000, "buffer");
    $display("t_wake_frag done");
  endtask

  task automatic t_wake_sync;
    wr(`UABW_OFF_CTRL, 32'h0000_003B);
    remote.send_break(13, T);
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0039, "measure waits past break");
    rd_chk(`UABW_OFF_RBUF, 32'h0000_0000, "buffer");
    @(negedge pclk);
    chk({31'h0, receive_flag}, 32'h0, "flag cleared");
    remote.send_byte(8'h55, T);
    wait_flag(50);
    rd_chk(`UABW_OFF_CTRL, 32'h0000_0038, "enable self-clear");
    chk_div(32);
    $display("t_wake_sync done");
  endtask

  // Main sequence
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_measure(2'b00, 512);
    t_measure(2'b01, 128);
    t_measure(2'b10, 128);
    t_measure(2'b11, 32);
    t_abort();
    t_wake();
    t_wake_frag();
    t_wake_sync();
    test_done();
  end
endmodule // uart_autobaud_and_wake_on_break_test
`default_nettype wire
